// ===== logic/pdt_pwm_timer.sv
// PWM timer top: APB register slave, divided free-running counter with period and duty compare.
// Assumes an APB3 master on pclk and a low-pass filter outside that smooths pwm_out.
`include "pdt_params.svh"

module pdt_pwm_timer
	import pdt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`PDT_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic pwm_out
);

	pdt_core_state_t s_reg;
	pdt_core_state_t s_next;
	logic tick;
	logic running;
	logic period_hit;
	logic duty_hit;
	logic clr_req;
	logic load_duty;
	logic [`PDT_CNT_W-1:0] limit;

	function automatic logic reg_known(logic [`PDT_ADDR_W-1:0] a);
		logic r;
		r = 1'b0;
		if (a == `PDT_OFF_CTRL) begin
			r = 1'b1;
		end else if (a == `PDT_OFF_PERIOD) begin
			r = 1'b1;
		end else if (a == `PDT_OFF_DUTY) begin
			r = 1'b1;
		end else if (a == `PDT_OFF_CHCTL) begin
			r = 1'b1;
		end else if (a == `PDT_OFF_COUNT) begin
			r = 1'b1;
		end else if (a == `PDT_OFF_STATUS) begin
			r = 1'b1;
		end
		return r;
	endfunction

	// In up mode a stored zero period means the full counter width; up-down mode holds the counter at zero.
	function automatic logic [`PDT_CNT_W-1:0] top_of(logic [`PDT_CNT_W-1:0] latch);
		return (latch == `PDT_CNT_ZERO) ? `PDT_CNT_MAX : latch;
	endfunction

	function automatic logic [31:0] read_word(logic [`PDT_ADDR_W-1:0] a, pdt_core_state_t s, logic lvl);
		logic [31:0] w;
		w = '0;
		if (a == `PDT_OFF_CTRL) begin
			w[`PDT_CTRL_MODE_MSB:`PDT_CTRL_MODE_LSB] = s.mode;
			w[`PDT_CTRL_SRC_MSB:`PDT_CTRL_SRC_LSB] = s.src;
			w[`PDT_CTRL_DIV_MSB:`PDT_CTRL_DIV_LSB] = s.div_sel;
		end else if (a == `PDT_OFF_PERIOD) begin
			w[`PDT_CNT_W-1:0] = s.period_register;
		end else if (a == `PDT_OFF_DUTY) begin
			w[`PDT_CNT_W-1:0] = s.duty_compare_register;
		end else if (a == `PDT_OFF_CHCTL) begin
			w[`PDT_CHCTL_LLOAD_BIT] = s.latch_load_at_zero;
			w[`PDT_CHCTL_OMODE_MSB:`PDT_CHCTL_OMODE_LSB] = s.out_mode;
			w[`PDT_CHCTL_OBIT_BIT] = s.out_bit;
		end else if (a == `PDT_OFF_COUNT) begin
			w[`PDT_CNT_W-1:0] = s.pwm_counter;
		end else if (a == `PDT_OFF_STATUS) begin
			w[`PDT_STAT_OUT_BIT] = lvl;
			w[`PDT_STAT_DIR_BIT] = s.dir_up;
		end
		return w;
	endfunction

	// Only the subsystem clock exists inside this block; the other sources are pins we do not have, so they halt.
	assign running = (s_reg.mode != PDT_MODE_STOP) && (s_reg.src == PDT_SRC_SUBSYS);

	pdt_clk_div u_div (
		.pclk(pclk),
		.presetn(presetn),
		.run(running),
		.div_sel(s_reg.div_sel),
		.tick(tick)
	);

	always_comb begin
		s_next = s_reg;
		clr_req = 1'b0;
		limit = top_of(s_reg.period_compare_latch);
		period_hit = tick && (s_reg.pwm_counter == limit);
		duty_hit = tick && (s_reg.pwm_counter == s_reg.duty_latch);

		if (psel && !penable && !pwrite) begin
			s_next.rdata = read_word(paddr, s_reg, pwm_out);
		end
		if (psel && penable && pwrite) begin
			if (paddr == `PDT_OFF_CTRL) begin
				s_next.mode = pdt_mode_t'(pwdata[`PDT_CTRL_MODE_MSB:`PDT_CTRL_MODE_LSB]);
				s_next.src = pdt_src_t'(pwdata[`PDT_CTRL_SRC_MSB:`PDT_CTRL_SRC_LSB]);
				s_next.div_sel = pwdata[`PDT_CTRL_DIV_MSB:`PDT_CTRL_DIV_LSB];
				clr_req = pwdata[`PDT_CTRL_CLR_BIT];
			end else if (paddr == `PDT_OFF_PERIOD) begin
				s_next.period_register = pwdata[`PDT_CNT_W-1:0];
			end else if (paddr == `PDT_OFF_DUTY) begin
				s_next.duty_compare_register = pwdata[`PDT_CNT_W-1:0];
			end else if (paddr == `PDT_OFF_CHCTL) begin
				s_next.latch_load_at_zero = pwdata[`PDT_CHCTL_LLOAD_BIT];
				s_next.out_mode = pdt_outmode_t'(pwdata[`PDT_CHCTL_OMODE_MSB:`PDT_CHCTL_OMODE_LSB]);
				s_next.out_bit = pwdata[`PDT_CHCTL_OBIT_BIT];
			end
		end

		// The compare logic never looks at the written period directly, only at this copy.
		s_next.period_compare_latch = s_reg.period_register;

		if (clr_req) begin
			s_next.pwm_counter = `PDT_CNT_ZERO;
			s_next.dir_up = 1'b1;
		end else if (s_reg.mode == PDT_MODE_UP && s_reg.pwm_counter > limit) begin
			s_next.pwm_counter = `PDT_CNT_ZERO;
		end else if (tick) begin
			case (s_reg.mode)
				PDT_MODE_UP: begin
					if (s_reg.pwm_counter == limit) begin
						s_next.pwm_counter = `PDT_CNT_ZERO;
					end else begin
						s_next.pwm_counter = s_reg.pwm_counter + `PDT_CNT_W'(1);
					end
				end
				PDT_MODE_CONT: begin
					s_next.pwm_counter = s_reg.pwm_counter + `PDT_CNT_W'(1);
				end
				PDT_MODE_UPDN: begin
					if (s_reg.period_compare_latch == `PDT_CNT_ZERO) begin
						s_next.pwm_counter = `PDT_CNT_ZERO;
					end else if (s_reg.dir_up && s_reg.pwm_counter >= s_reg.period_compare_latch) begin
						s_next.dir_up = 1'b0;
						s_next.pwm_counter = s_reg.pwm_counter - `PDT_CNT_W'(1);
					end else if (!s_reg.dir_up && s_reg.pwm_counter == `PDT_CNT_ZERO) begin
						s_next.dir_up = 1'b1;
						s_next.pwm_counter = s_reg.pwm_counter + `PDT_CNT_W'(1);
					end else if (s_reg.dir_up) begin
						s_next.pwm_counter = s_reg.pwm_counter + `PDT_CNT_W'(1);
					end else begin
						s_next.pwm_counter = s_reg.pwm_counter - `PDT_CNT_W'(1);
					end
				end
				default: begin
					s_next.pwm_counter = s_reg.pwm_counter;
				end
			endcase
		end

		// A stopped counter sitting at zero also accepts the load, so the initial duty reaches the latch.
		load_duty = (tick && s_next.pwm_counter == `PDT_CNT_ZERO) ||
			(!running && s_reg.pwm_counter == `PDT_CNT_ZERO);
		if (!s_reg.latch_load_at_zero || load_duty) begin
			s_next.duty_latch = s_reg.duty_compare_register;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Duty over period comes from the reset/set mode on these two compare events.
	pdt_out_unit u_out (
		.pclk(pclk),
		.presetn(presetn),
		.period_hit(period_hit),
		.duty_hit(duty_hit),
		.out_mode(s_reg.out_mode),
		.out_bit(s_reg.out_bit),
		.pwm_out(pwm_out)
	);

	assign prdata = s_reg.rdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !reg_known(paddr);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_period_write;
		psel && penable && pwrite && paddr == `PDT_OFF_PERIOD;
	endsequence

	sequence s_up_top_tick;
		s_reg.mode == PDT_MODE_UP && tick && s_reg.pwm_counter == limit && !clr_req;
	endsequence

	a_up_restart: assert property (s_up_top_tick |=> s_reg.pwm_counter == `PDT_CNT_ZERO) else $error("up mode did not restart at period");
	a_up_period_len: assert property (s_up_top_tick ##1 (s_reg.mode == PDT_MODE_UP && tick && !clr_req && $stable(s_reg.period_compare_latch)) |=> s_reg.pwm_counter == 16'h0001) else $error("up period length wrong");
	a_cont_wrap: assert property (s_reg.mode == PDT_MODE_CONT && tick && !clr_req && s_reg.pwm_counter == `PDT_CNT_MAX |=> s_reg.pwm_counter == `PDT_CNT_ZERO) else $error("continuous mode did not wrap");
	a_zero_full: assert property (s_reg.mode == PDT_MODE_UP && s_reg.period_compare_latch == `PDT_CNT_ZERO && tick && !clr_req && s_reg.pwm_counter == 16'hFFFE |=> s_reg.pwm_counter == `PDT_CNT_MAX) else $error("zero period did not count full width");
	a_over_restart: assert property (s_reg.mode == PDT_MODE_UP && s_reg.pwm_counter > limit |=> s_reg.pwm_counter == `PDT_CNT_ZERO) else $error("counter above period not restarted");
	a_updn_turn: assert property (s_reg.mode == PDT_MODE_UPDN && tick && !clr_req && s_reg.dir_up && s_reg.period_compare_latch != `PDT_CNT_ZERO && s_reg.pwm_counter == s_reg.period_compare_latch |=> !s_reg.dir_up && s_reg.pwm_counter == $past(s_reg.pwm_counter) - 16'h0001) else $error("up-down did not turn at period");
	a_latch_follow: assert property (s_period_write |=> ##1 s_reg.period_compare_latch == $past(pwdata[15:0], 2)) else $error("period latch not loaded from register");
	a_duty_held: assert property (s_reg.latch_load_at_zero && !load_duty |=> $stable(s_reg.duty_latch)) else $error("duty latch changed away from zero");
	a_rst_set_high: assert property (s_reg.out_mode == PDT_OUT_RST_SET && period_hit |=> pwm_out) else $error("reset/set output not set at period");

endmodule

// ===== logic/pdt_params.svh
// Constants of the PWM timer: register offsets, field positions, reset values and counter limits.
// Assumes a single 100 MHz clock and APB register access with byte addresses.
`ifndef PDT_PARAMS_SVH
`define PDT_PARAMS_SVH

`define PDT_CNT_W 16
`define PDT_CNT_MAX 16'hFFFF
`define PDT_CNT_ZERO 16'h0000
`define PDT_ADDR_W 8

`define PDT_OFF_CTRL 8'h00
`define PDT_OFF_PERIOD 8'h04
`define PDT_OFF_DUTY 8'h08
`define PDT_OFF_CHCTL 8'h0C
`define PDT_OFF_COUNT 8'h10
`define PDT_OFF_STATUS 8'h14

`define PDT_CTRL_MODE_LSB 0
`define PDT_CTRL_MODE_MSB 1
`define PDT_CTRL_SRC_LSB 2
`define PDT_CTRL_SRC_MSB 3
`define PDT_CTRL_DIV_LSB 4
`define PDT_CTRL_DIV_MSB 5
`define PDT_CTRL_CLR_BIT 6

`define PDT_CHCTL_LLOAD_BIT 0
`define PDT_CHCTL_OMODE_LSB 1
`define PDT_CHCTL_OMODE_MSB 3
`define PDT_CHCTL_OBIT_BIT 4

`define PDT_STAT_OUT_BIT 0
`define PDT_STAT_DIR_BIT 1

`define PDT_DIV_8 2'h3
`define PDT_DIV_CNT_W 3

`define PDT_RST_MODE 2'h0
`define PDT_RST_SRC 2'h0
`define PDT_RST_DIV 2'h0
`define PDT_RST_WORD 16'h0000
`define PDT_RST_OMODE 3'h0

`endif

// ===== logic/pdt_pkg.sv
// Types shared by the PWM timer modules: count modes, clock sources, output modes and state records.
// Assumes pdt_params.svh is compiled first.
`include "pdt_params.svh"

package pdt_pkg;

	typedef enum logic [1:0] {
		PDT_MODE_STOP = 2'b00,
		PDT_MODE_UP = 2'b01,
		PDT_MODE_CONT = 2'b10,
		PDT_MODE_UPDN = 2'b11
	} pdt_mode_t;

	typedef enum logic [1:0] {
		PDT_SRC_EXT_A = 2'b00,
		PDT_SRC_AUX = 2'b01,
		PDT_SRC_SUBSYS = 2'b10,
		PDT_SRC_EXT_B = 2'b11
	} pdt_src_t;

	typedef enum logic [2:0] {
		PDT_OUT_BIT = 3'b000,
		PDT_OUT_SET = 3'b001,
		PDT_OUT_TOG_RST = 3'b010,
		PDT_OUT_SET_RST = 3'b011,
		PDT_OUT_TOGGLE = 3'b100,
		PDT_OUT_RESET = 3'b101,
		PDT_OUT_TOG_SET = 3'b110,
		PDT_OUT_RST_SET = 3'b111
	} pdt_outmode_t;

	typedef struct packed {
		logic [`PDT_DIV_CNT_W-1:0] cnt;
	} pdt_div_state_t;

	typedef struct packed {
		logic level;
	} pdt_out_state_t;

	typedef struct packed {
		pdt_mode_t mode;
		pdt_src_t src;
		logic [1:0] div_sel;
		logic [`PDT_CNT_W-1:0] period_register;
		logic [`PDT_CNT_W-1:0] period_compare_latch;
		logic [`PDT_CNT_W-1:0] duty_compare_register;
		logic [`PDT_CNT_W-1:0] duty_latch;
		logic latch_load_at_zero;
		pdt_outmode_t out_mode;
		logic out_bit;
		logic [`PDT_CNT_W-1:0] pwm_counter;
		logic dir_up;
		logic [31:0] rdata;
	} pdt_core_state_t;

endpackage

// ===== logic/pdt_clk_div.sv
// Tick divider: turns the system clock into a one-cycle count enable at 1/1, 1/2, 1/4 or 1/8 rate.
// Assumes run drops whenever the counter is stopped, so a restart begins with a full division.
`include "pdt_params.svh"

module pdt_clk_div
	import pdt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [1:0] div_sel,
	output logic tick
);

	pdt_div_state_t s_reg;
	pdt_div_state_t s_next;
	logic [`PDT_DIV_CNT_W-1:0] limit;

	always_comb begin
		limit = `PDT_DIV_CNT_W'((4'h1 << div_sel) - 4'h1);
		// A count left above a smaller new limit ticks at once, so a divider change never skips ticks.
		tick = run && (s_reg.cnt >= limit);
		s_next = s_reg;
		if (!run || tick) begin
			s_next.cnt = '0;
		end else begin
			s_next.cnt = s_reg.cnt + `PDT_DIV_CNT_W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_div_eight_spacing: assert property (tick ##1 (run && div_sel == `PDT_DIV_8 && !tick)[*7] ##1 (run && div_sel == `PDT_DIV_8) |-> tick) else $error("divide-by-8 tick spacing wrong");
	a_div_one_every: assert property (run && div_sel == 2'h0 |-> tick) else $error("divide-by-1 missed a tick");

endmodule

// ===== logic/pdt_out_unit.sv
// Output unit of the duty channel: applies the output mode to the period and duty compare events.
// Assumes both events arrive as one-cycle pulses on counter ticks.
`include "pdt_params.svh"

module pdt_out_unit
	import pdt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic period_hit,
	input wire logic duty_hit,
	input wire pdt_outmode_t out_mode,
	input wire logic out_bit,
	output logic pwm_out
);

	pdt_out_state_t s_reg;
	pdt_out_state_t s_next;

	// When both events coincide the period action wins, so in reset/set mode a duty equal to the period gives a full-high output.
	function automatic logic next_level(pdt_outmode_t m, logic lvl, logic e0, logic e1, logic ob);
		logic r;
		r = lvl;
		case (m)
			PDT_OUT_BIT: r = ob;
			PDT_OUT_SET: if (e1) r = 1'b1;
			PDT_OUT_TOG_RST: if (e0) r = 1'b0; else if (e1) r = !lvl;
			PDT_OUT_SET_RST: if (e0) r = 1'b0; else if (e1) r = 1'b1;
			PDT_OUT_TOGGLE: if (e1) r = !lvl;
			PDT_OUT_RESET: if (e1) r = 1'b0;
			PDT_OUT_TOG_SET: if (e0) r = 1'b1; else if (e1) r = !lvl;
			PDT_OUT_RST_SET: if (e0) r = 1'b1; else if (e1) r = 1'b0;
			default: r = lvl;
		endcase
		return r;
	endfunction

	always_comb begin
		s_next = s_reg;
		s_next.level = next_level(out_mode, s_reg.level, period_hit, duty_hit, out_bit);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pwm_out = s_reg.level;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_out_quiet: assert property (!period_hit && !duty_hit && out_mode != PDT_OUT_BIT |=> $stable(pwm_out)) else $error("output moved without an event");
	a_out_rst_set: assert property (out_mode == PDT_OUT_RST_SET && duty_hit && !period_hit |=> !pwm_out) else $error("reset/set output not cleared at duty");

endmodule

// ===== tb/pdt_filter_model.sv
// Stand-in for the RC low-pass filter on the PWM pin: integrates the pin level one sample per clock.
// Assumes pwm_in is a clean registered level, sampled on the rising edge of pclk.
module pdt_filter_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pwm_in,
	output logic [31:0] hi_cnt,
	output logic [31:0] tot_cnt
);
	timeunit 1ns;
	timeprecision 1ps;

	// The high and total sample counts stand for the charge and the time the filter sees.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_cnt <= 32'h0000_0000;
			tot_cnt <= 32'h0000_0000;
		end else begin
			tot_cnt <= tot_cnt + 32'h0000_0001;
			if (pwm_in === 1'b1) begin
				hi_cnt <= hi_cnt + 32'h0000_0001;
			end
		end
	end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the PWM timer: APB access, PWM pin timing and counter modes.
// Assumes the design files under logic/ and the filter model in tb/pdt_filter_model.sv.
`include "pdt_params.svh"

module testbench
	import pdt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int MAX_CYCLES = 90000;
	localparam logic [31:0] PER = 32'h0000_0009;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [`PDT_ADDR_W-1:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pwm_out;
	logic [31:0] hi_cnt;
	logic [31:0] tot_cnt;
	logic [31:0] rd;
	logic [31:0] a;
	logic [31:0] b;
	logic err;
	int per;
	int hi;
	int n_fail = 0;
	int num_checks = 0;
	int cycles = 0;

	pdt_pwm_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out));
	pdt_filter_model filt (.pclk(pclk), .presetn(presetn), .pwm_in(pwm_out), .hi_cnt(hi_cnt), .tot_cnt(tot_cnt));

	initial begin
		forever #5 pclk = ~pclk;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == MAX_CYCLES) begin
			n_fail++;
			summarize();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer; the request is held until pready is seen high at a rising edge.
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
		output logic [31:0] data, output logic slverr);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		data = prdata;
		slverr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [31:0] ctrl(input pdt_mode_t m, input logic [1:0] d);
		return {26'h0, d, PDT_SRC_SUBSYS, m};
	endfunction

	// The first interval after a change may straddle two settings, so the second one is measured.
	task automatic measure(output int p, output int h);
		logic [31:0] h0;
		logic [31:0] t0;
		@(posedge pwm_out);
		@(posedge pwm_out);
		@(posedge pclk);
		h0 = hi_cnt;
		t0 = tot_cnt;
		@(posedge pwm_out);
		@(posedge pclk);
		p = tot_cnt - t0;
		h = hi_cnt - h0;
	endtask

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0, rd, err);
			check("reset value", rd, 32'h0);
			check("reset error flag", {31'h0, err}, 32'h0);
		end
		apb(1'b0, 8'h18, 32'h0, rd, err);
		check("unmapped error flag", {31'h0, err}, 32'h1);
		$display("test registers done");
		apb(1'b1, `PDT_OFF_PERIOD, PER, rd, err);
		apb(1'b1, `PDT_OFF_CHCTL, {27'h0, 1'b0, PDT_OUT_RST_SET, 1'b1}, rd, err);
		apb(1'b1, `PDT_OFF_DUTY, 32'h0, rd, err);
		apb(1'b1, `PDT_OFF_CTRL, ctrl(PDT_MODE_UP, 2'h0), rd, err);
		measure(per, hi);
		check("zero duty period", 32'(per), PER + 1);
		check("zero duty high time", 32'(hi), 32'h1);
		apb(1'b1, `PDT_OFF_DUTY, 32'h3, rd, err);
		for (int d = 0; d < 4; d++) begin
			apb(1'b1, `PDT_OFF_CTRL, ctrl(PDT_MODE_UP, 2'(d)), rd, err);
			measure(per, hi);
			check("up period", 32'(per), (PER + 1) << d);
			check("up high time", 32'(hi), 32'h4 << d);
		end
		apb(1'b1, `PDT_OFF_DUTY, 32'h6, rd, err);
		measure(per, hi);
		check("refreshed high time", 32'(hi), 32'h7 << 3);
		apb(1'b1, `PDT_OFF_PERIOD, 32'h0000_03E8, rd, err);
		apb(1'b1, `PDT_OFF_CTRL, ctrl(PDT_MODE_UP, 2'h0), rd, err);
		measure(per, hi);
		check("1000-count period", 32'(per), 32'h0000_03E9);
		check("1000-count high time", 32'(hi), 32'h7);
		apb(1'b1, `PDT_OFF_PERIOD, PER, rd, err);
		$display("test pwm timing done");
		apb(1'b1, `PDT_OFF_CTRL, ctrl(PDT_MODE_CONT, 2'h0) | 32'h40, rd, err);
		repeat (40) @(posedge pclk);
		apb(1'b0, `PDT_OFF_COUNT, 32'h0, a, err);
		check("continuous passes period", {31'h0, a[15:0] > PER[15:0]}, 32'h1);
		apb(1'b1, `PDT_OFF_CTRL, ctrl(PDT_MODE_UP, 2'h0), rd, err);
		apb(1'b0, `PDT_OFF_COUNT, 32'h0, a, err);
		check("up entry restarts", {31'h0, a[15:0] <= PER[15:0]}, 32'h1);
		apb(1'b1, `PDT_OFF_CTRL, ctrl(PDT_MODE_CONT, 2'h0), rd, err);
		apb(1'b0, `PDT_OFF_COUNT, 32'h0, a, err);
		apb(1'b0, `PDT_OFF_COUNT, 32'h0, b, err);
		repeat (65536) @(posedge pclk);
		apb(1'b0, `PDT_OFF_COUNT, 32'h0, rd, err);
		// A full 65536-cycle gap leaves the step equal only if the counter wrapped.
		check("continuous wrap", {16'h0, rd[15:0] - b[15:0]}, {16'h0, b[15:0] - a[15:0]});
		apb(1'b1, `PDT_OFF_PERIOD, 32'h0, rd, err);
		apb(1'b1, `PDT_OFF_CTRL, ctrl(PDT_MODE_UP, 2'h0) | 32'h40, rd, err);
		repeat (40) @(posedge pclk);
		apb(1'b0, `PDT_OFF_COUNT, 32'h0, a, err);
		check("zero period full width", {31'h0, a[15:0] > 16'h0028}, 32'h1);
		$display("test counter modes done");
		apb(1'b1, `PDT_OFF_PERIOD, PER, rd, err);
		apb(1'b1, `PDT_OFF_CTRL, ctrl(PDT_MODE_UPDN, 2'h0) | 32'h40, rd, err);
		measure(per, hi);
		check("up-down period", 32'(per), PER << 1);
		apb(1'b1, `PDT_OFF_CHCTL, 32'h10, rd, err);
		repeat (3) @(posedge pclk);
		check("out bit drives pin", {31'h0, pwm_out}, 32'h1);
		apb(1'b0, `PDT_OFF_STATUS, 32'h0, rd, err);
		check("status pin level", rd & 32'h1, 32'h1);
		apb(1'b1, `PDT_OFF_CHCTL, 32'h0, rd, err);
		repeat (3) @(posedge pclk);
		check("out bit low", {31'h0, pwm_out}, 32'h0);
		$display("test output modes done");
		summarize();
	end
endmodule
